// ===== common/hmmbx_defines.svh
`ifndef HMMBX_DEFINES_SVH
`define HMMBX_DEFINES_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define HMMBX_ADDR_CLKLESS 24'h000001
`define HMMBX_ADDR_WAKE 24'h000004
`define HMMBX_ADDR_HEADER 24'h00108c
`define HMMBX_ADDR_RX_STATUS 24'h001070
`define HMMBX_ADDR_RX_ADDR 24'h001084
`define HMMBX_ADDR_TX_DOORBELL 24'h001078
`define HMMBX_ADDR_TX_DONE 24'h00106c
`define HMMBX_ADDR_TX_BUFADDR 24'h150400

// ----------------------------------------
// Field positions and values
// ----------------------------------------
`define HMMBX_BIT_WAKE_REQ 1
`define HMMBX_BIT_RX_PEND 0
`define HMMBX_BIT_RX_DONE 1
`define HMMBX_BIT_DOORBELL 1
`define HMMBX_BIT_TX_DONE 1
`define HMMBX_SIZE_LSB 2
`define HMMBX_SIZE_MSB 13
`define HMMBX_DONE_ADDR_SHIFT 2
`define HMMBX_WAKE_VALUE 32'h00005678
`define HMMBX_SLEEP_VALUE 32'h00004321
`define HMMBX_HDR_BYTES 16'h0004
`define HMMBX_ZERO32 32'h00000000

`endif

// ===== common/hmmbx_pkg.sv
package hmmbx_pkg;
	typedef enum logic [2:0] {
		HMMBX_TX_IDLE = 3'b000,
		HMMBX_TX_RUNG = 3'b001,
		HMMBX_TX_GRANTED = 3'b011,
		HMMBX_TX_DONE = 3'b010
	} hmmbx_tx_state_t;

	typedef enum logic [1:0] {
		HMMBX_RX_IDLE = 2'b00,
		HMMBX_RX_PEND = 2'b01,
		HMMBX_RX_READ = 2'b11
	} hmmbx_rx_state_t;

	typedef struct packed {
		logic [7:0] group_id;
		logic [7:0] opcode;
		logic [15:0] length;
	} hmmbx_header_t;
endpackage

// ===== common/hmmbx_stream_if.sv
`timescale 1ns/1ps
interface hmmbx_stream_if #(parameter int WIDTH = 32) ();
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// ===== verilog/hmmbx_fifo.sv
`timescale 1ns/1ps
module hmmbx_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input wire logic core_clk,
	input wire logic rst_b,
	hmmbx_stream_if.snk wr,
	hmmbx_stream_if.src rd
);
	localparam int AW = $clog2(DEPTH);

	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
			$error("hmmbx_fifo: DEPTH must be a power of two >= 2");
	end

	typedef struct packed {
		logic [AW:0] wptr;
		logic [AW:0] rptr;
		logic [WIDTH-1:0] out;
		logic out_valid;
	} hmmbx_fifo_st_t;

	logic [WIDTH-1:0] mem [DEPTH];
	hmmbx_fifo_st_t st_reg;
	hmmbx_fifo_st_t st_next;
	logic full;
	logic empty;
	logic push;
	logic pop;

	// ----------------------------------------
	// Pointers; read data leaves from a register
	// ----------------------------------------
	always_comb begin
		full = (st_reg.wptr[AW-1:0] == st_reg.rptr[AW-1:0]) && (st_reg.wptr[AW] != st_reg.rptr[AW]);
		empty = st_reg.wptr == st_reg.rptr;
		push = wr.valid && !full;
		pop = !empty && (!st_reg.out_valid || rd.ready);
		st_next = st_reg;
		if (push)
			st_next.wptr = st_reg.wptr + 1'b1;
		if (rd.ready && st_reg.out_valid)
			st_next.out_valid = 1'b0;
		if (pop) begin
			st_next.rptr = st_reg.rptr + 1'b1;
			st_next.out = mem[st_reg.rptr[AW-1:0]];
			st_next.out_valid = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b)
			st_reg <= '0;
		else
			st_reg <= st_next;
		if (push)
			mem[st_reg.wptr[AW-1:0]] <= wr.data;
	end

	assign wr.ready = !full;
	assign rd.valid = st_reg.out_valid;
	assign rd.data = st_reg.out;
endmodule

// ===== verilog/hmmbx_hdr_unpack.sv
`timescale 1ns/1ps
`include "hmmbx_defines.svh"
module hmmbx_hdr_unpack (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic load,
	input wire logic [31:0] word,
	output hmmbx_pkg::hmmbx_header_t hdr,
	output logic [15:0] total_bytes
);
	typedef struct packed {
		hmmbx_pkg::hmmbx_header_t hdr;
		logic [15:0] total;
	} hmmbx_hdr_st_t;

	hmmbx_hdr_st_t st_reg;
	hmmbx_hdr_st_t st_next;

	always_comb begin
		st_next = st_reg;
		if (load) begin
			st_next.hdr.group_id = word[7:0];
			st_next.hdr.opcode = word[15:8];
			st_next.hdr.length = word[31:16];
			// Payload excludes the header, so add it back for the buffer size
			st_next.total = word[31:16] + `HMMBX_HDR_BYTES;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign hdr = st_reg.hdr;
	assign total_bytes = st_reg.total;
endmodule

// ===== verilog/hmmbx_mailbox.sv
// What this block does
// - Wake via clockless bit plus wake register
// - Doorbell bit 1 raises device interrupt
// - Device clears doorbell after buffer allocation
// - Device presents allocated address at tx_buffer_address
// - Done bit 1 is completion interrupt
// - Receive status bit 0 flags pending
// - Writing zero to bit 0 clears pending
// - Device reports outbound buffer start address
// - Size reported in status bits 13:2
// - Receive-done bit 1 frees device buffer
// - Header field one: 8-bit group
// - Header field two: 8-bit opcode
// - 16-bit payload length excludes header
// - Completions return later as outbound messages
`timescale 1ns/1ps
`include "hmmbx_defines.svh"
module hmmbx_mailbox #(
	parameter int ADDR_W = 24,
	parameter int FIFO_DEPTH = 16
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic reg_rvalid,
	output logic awake,
	output logic cpu_tx_irq,
	input wire logic cpu_alloc_valid,
	input wire logic [31:0] cpu_alloc_addr,
	output logic cpu_done_irq,
	output logic [31:0] cpu_done_addr,
	output logic [7:0] cpu_hdr_group,
	output logic [7:0] cpu_hdr_opcode,
	output logic [15:0] cpu_hdr_total,
	input wire logic cpu_msg_valid,
	input wire logic [31:0] cpu_msg_addr,
	input wire logic [11:0] cpu_msg_size,
	output logic cpu_msg_ready,
	output logic cpu_rx_free,
	output logic [31:0] cpu_rx_free_addr
);
	initial begin
		if (ADDR_W < 24 || FIFO_DEPTH < 2)
			$error("hmmbx_mailbox: ADDR_W must cover the buffer address register");
	end

	typedef struct packed {
		logic clkless_wake;
		logic [31:0] wake_word;
		logic awake;
		logic [31:0] header;
		hmmbx_pkg::hmmbx_tx_state_t tx_state;
		logic [31:0] tx_bufaddr;
		logic tx_irq;
		logic done_irq;
		logic [31:0] done_addr;
		hmmbx_pkg::hmmbx_rx_state_t rx_state;
		logic rx_pend;
		logic [11:0] rx_size;
		logic [31:0] rx_addr;
		logic rx_free;
		logic [31:0] rdata;
		logic rvalid;
	} hmmbx_st_t;

	hmmbx_st_t st_reg;
	hmmbx_st_t st_next;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [23:0] reg_a);
		hit = a == ADDR_W'(reg_a);
	endfunction

	// ----------------------------------------
	// Outbound message queue
	// ----------------------------------------
	// Firmware may post messages faster than the host drains them; they wait here.
	hmmbx_stream_if #(.WIDTH(44)) q_in ();
	hmmbx_stream_if #(.WIDTH(44)) q_out ();
	logic q_take;

	assign q_in.valid = cpu_msg_valid;
	assign q_in.data = {cpu_msg_size, cpu_msg_addr};
	assign q_out.ready = q_take;

	hmmbx_fifo #(.WIDTH(44), .DEPTH(FIFO_DEPTH)) u_fifo (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.wr(q_in),
		.rd(q_out)
	);

	hmmbx_pkg::hmmbx_header_t hdr;
	logic [15:0] hdr_total;

	hmmbx_hdr_unpack u_hdr (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.load(reg_wr && hit(reg_addr, `HMMBX_ADDR_HEADER) && st_reg.awake),
		.word(reg_wdata),
		.hdr(hdr),
		.total_bytes(hdr_total)
	);

	logic wr_ok;
	logic do_wr_clk;
	logic do_wr_wake;
	logic do_wr_hdr;
	logic do_wr_bell;
	logic do_wr_done;
	logic do_wr_rxs;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		wr_ok = reg_wr && st_reg.awake;
		do_wr_clk = reg_wr && hit(reg_addr, `HMMBX_ADDR_CLKLESS);
		do_wr_wake = reg_wr && hit(reg_addr, `HMMBX_ADDR_WAKE);
		do_wr_hdr = wr_ok && hit(reg_addr, `HMMBX_ADDR_HEADER);
		do_wr_bell = wr_ok && hit(reg_addr, `HMMBX_ADDR_TX_DOORBELL);
		do_wr_done = wr_ok && hit(reg_addr, `HMMBX_ADDR_TX_DONE);
		do_wr_rxs = wr_ok && hit(reg_addr, `HMMBX_ADDR_RX_STATUS);
		q_take = 1'b0;
		st_next = st_reg;
		st_next.tx_irq = 1'b0;
		st_next.done_irq = 1'b0;
		st_next.rx_free = 1'b0;
		st_next.rvalid = reg_rd;

		// Clockless access path stays usable while asleep
		if (do_wr_clk)
			st_next.clkless_wake = reg_wdata[`HMMBX_BIT_WAKE_REQ];
		if (do_wr_wake)
			st_next.wake_word = reg_wdata;
		st_next.awake = st_next.clkless_wake && (st_next.wake_word == `HMMBX_WAKE_VALUE);

		if (do_wr_hdr)
			st_next.header = reg_wdata;

		case (st_reg.tx_state)
			hmmbx_pkg::HMMBX_TX_IDLE: begin
				if (do_wr_bell && reg_wdata[`HMMBX_BIT_DOORBELL]) begin
					st_next.tx_state = hmmbx_pkg::HMMBX_TX_RUNG;
					st_next.tx_irq = 1'b1;
					st_next.tx_bufaddr = `HMMBX_ZERO32;
				end
			end
			hmmbx_pkg::HMMBX_TX_RUNG: begin
				if (cpu_alloc_valid) begin
					// Address lands with the doorbell clear so a poll never sees stale data
					st_next.tx_bufaddr = cpu_alloc_addr;
					st_next.tx_state = hmmbx_pkg::HMMBX_TX_GRANTED;
				end
			end
			hmmbx_pkg::HMMBX_TX_GRANTED: begin
				if (st_reg.tx_bufaddr == `HMMBX_ZERO32)
					st_next.tx_state = hmmbx_pkg::HMMBX_TX_IDLE;
				else if (do_wr_done && reg_wdata[`HMMBX_BIT_TX_DONE])
					st_next.tx_state = hmmbx_pkg::HMMBX_TX_DONE;
			end
			hmmbx_pkg::HMMBX_TX_DONE: begin
				st_next.tx_state = hmmbx_pkg::HMMBX_TX_IDLE;
			end
			default: st_next.tx_state = hmmbx_pkg::HMMBX_TX_IDLE;
		endcase
		if (do_wr_done && reg_wdata[`HMMBX_BIT_TX_DONE]) begin
			st_next.done_irq = 1'b1;
			st_next.done_addr = reg_wdata >> `HMMBX_DONE_ADDR_SHIFT;
		end

		case (st_reg.rx_state)
			hmmbx_pkg::HMMBX_RX_IDLE: begin
				if (q_out.valid) begin
					q_take = 1'b1;
					st_next.rx_addr = q_out.data[31:0];
					st_next.rx_size = q_out.data[43:32];
					st_next.rx_pend = 1'b1;
					st_next.rx_state = hmmbx_pkg::HMMBX_RX_PEND;
				end
			end
			hmmbx_pkg::HMMBX_RX_PEND, hmmbx_pkg::HMMBX_RX_READ: begin
				if (do_wr_rxs && !reg_wdata[`HMMBX_BIT_RX_PEND]) begin
					st_next.rx_pend = 1'b0;
					st_next.rx_state = hmmbx_pkg::HMMBX_RX_READ;
				end
				if (do_wr_rxs && reg_wdata[`HMMBX_BIT_RX_DONE]) begin
					// Freeing also drops pending so a skipped clear cannot wedge the queue
					st_next.rx_free = 1'b1;
					st_next.rx_pend = 1'b0;
					st_next.rx_size = 12'h000;
					st_next.rx_state = hmmbx_pkg::HMMBX_RX_IDLE;
				end
			end
			default: st_next.rx_state = hmmbx_pkg::HMMBX_RX_IDLE;
		endcase

		// ----------------------------------------
		// Read mux
		// ----------------------------------------
		st_next.rdata = `HMMBX_ZERO32;
		if (reg_rd) begin
			if (hit(reg_addr, `HMMBX_ADDR_CLKLESS))
				st_next.rdata[`HMMBX_BIT_WAKE_REQ] = st_reg.clkless_wake;
			else if (hit(reg_addr, `HMMBX_ADDR_WAKE))
				st_next.rdata = st_reg.wake_word;
			else if (st_reg.awake) begin
				if (hit(reg_addr, `HMMBX_ADDR_HEADER))
					st_next.rdata = st_reg.header;
				else if (hit(reg_addr, `HMMBX_ADDR_TX_DOORBELL))
					st_next.rdata[`HMMBX_BIT_DOORBELL] = st_reg.tx_state == hmmbx_pkg::HMMBX_TX_RUNG;
				else if (hit(reg_addr, `HMMBX_ADDR_TX_BUFADDR))
					st_next.rdata = st_reg.tx_bufaddr;
				else if (hit(reg_addr, `HMMBX_ADDR_RX_STATUS)) begin
					st_next.rdata[`HMMBX_BIT_RX_PEND] = st_reg.rx_pend;
					st_next.rdata[`HMMBX_SIZE_MSB:`HMMBX_SIZE_LSB] = st_reg.rx_size;
				end else if (hit(reg_addr, `HMMBX_ADDR_RX_ADDR))
					st_next.rdata = st_reg.rx_addr;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			st_reg <= '0;
			st_reg.wake_word <= `HMMBX_SLEEP_VALUE;
		end else
			st_reg <= st_next;
	end

	// ----------------------------------------
	// Outputs, all from flip-flops except cpu_msg_ready, which is decoded from the FIFO pointers
	// ----------------------------------------
	assign reg_rdata = st_reg.rdata;
	assign reg_rvalid = st_reg.rvalid;
	assign awake = st_reg.awake;
	assign cpu_tx_irq = st_reg.tx_irq;
	assign cpu_done_irq = st_reg.done_irq;
	assign cpu_done_addr = st_reg.done_addr;
	assign cpu_hdr_group = hdr.group_id;
	assign cpu_hdr_opcode = hdr.opcode;
	assign cpu_hdr_total = hdr_total;
	assign cpu_msg_ready = q_in.ready;
	assign cpu_rx_free = st_reg.rx_free;
	assign cpu_rx_free_addr = st_reg.rx_addr;
endmodule

// ===== verification/hmmbx_mailbox_checker.sv
`timescale 1ns/1ps
`include "hmmbx_defines.svh"
module hmmbx_mailbox_checker (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [23:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic awake,
	input wire logic cpu_tx_irq,
	input wire logic cpu_done_irq,
	input wire logic [31:0] cpu_done_addr,
	input wire logic [7:0] cpu_hdr_group,
	input wire logic [15:0] cpu_hdr_total,
	input wire logic cpu_rx_free
);
	// ----
	// Steps
	// ----
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	sequence s_wr(logic [23:0] a);
		awake && reg_wr && reg_addr == a;
	endsequence
	sequence s_hdr_out;
		cpu_hdr_group == $past(reg_wdata[7:0], 2) && cpu_hdr_total == $past(reg_wdata[31:16], 2) + 16'h0004;
	endsequence
	// ----
	// Properties
	// ----
	property p_rd_ans; reg_rd |=> reg_rvalid; endproperty
	property p_rd_one; !reg_rd |=> !reg_rvalid; endproperty
	property p_asleep; reg_rd && !awake && reg_addr > 24'h000004 |=> reg_rdata == 32'h0; endproperty
	property p_bad_wake; reg_wr && reg_addr == `HMMBX_ADDR_WAKE && reg_wdata != `HMMBX_WAKE_VALUE |=> !awake; endproperty
	property p_ring; s_wr(`HMMBX_ADDR_TX_DOORBELL) ##0 reg_wdata[1] |=> cpu_tx_irq; endproperty
	property p_done;
		s_wr(`HMMBX_ADDR_TX_DONE) ##0 reg_wdata[1] |=> cpu_done_irq && cpu_done_addr == $past(reg_wdata) >> 2;
	endproperty
	property p_free; s_wr(`HMMBX_ADDR_RX_STATUS) ##0 reg_wdata[1] |=> cpu_rx_free; endproperty
	property p_hdr; s_wr(`HMMBX_ADDR_HEADER) |-> ##2 s_hdr_out; endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
	a_rd_one: assert property (p_rd_one) else $error("answer without read");
	a_asleep: assert property (p_asleep) else $error("read data while asleep");
	a_bad_wake: assert property (p_bad_wake) else $error("awake without wake value");
	a_ring: assert property (p_ring) else $error("doorbell gave no irq");
	a_done: assert property (p_done) else $error("done irq or address wrong");
	a_free: assert property (p_free) else $error("rx done gave no free");
	a_hdr: assert property (p_hdr) else $error("header fields wrong");
endmodule
bind hmmbx_mailbox hmmbx_mailbox_checker u_chk (.*);

// ===== verification/hmmbx_host_model.sv
`timescale 1ns/1ps
`include "hmmbx_defines.svh"
module hmmbx_host_model (
	input wire logic core_clk,
	output logic reg_wr,
	output logic reg_rd,
	output logic [23:0] reg_addr,
	output logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 24'h0;
		reg_wdata = 32'h0;
	end
	// Released data is inverted so a stale word can never match
	task automatic wr(input logic [23:0] a, input logic [31:0] v);
		@(posedge core_clk);
		#1;
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = v;
		@(posedge core_clk);
		#1;
		reg_wr = 1'b0;
		reg_wdata = ~v;
	endtask
	task automatic rd(input logic [23:0] a, output logic [31:0] v);
		@(posedge core_clk);
		#1;
		reg_rd = 1'b1;
		reg_addr = a;
		@(posedge core_clk);
		#1;
		reg_rd = 1'b0;
		v = reg_rdata;
	endtask
	task automatic wake();
		wr(`HMMBX_ADDR_CLKLESS, 32'h00000002);
		wr(`HMMBX_ADDR_WAKE, `HMMBX_WAKE_VALUE);
	endtask
endmodule

// ===== verification/tb_top.sv
`timescale 1ns/1ps
`include "hmmbx_defines.svh"
module tb_top;
	logic core_clk, rst_b, reg_wr, reg_rd, reg_rvalid, awake, cpu_tx_irq, cpu_alloc_valid, cpu_done_irq;
	logic cpu_msg_valid, cpu_msg_ready, cpu_rx_free;
	logic [23:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, cpu_alloc_addr, cpu_done_addr, cpu_msg_addr, cpu_rx_free_addr, d, a;
	logic [7:0] cpu_hdr_group, cpu_hdr_opcode;
	logic [15:0] cpu_hdr_total;
	logic [11:0] cpu_msg_size;
	logic [43:0] q[$];
	int err_count = 0;
	int num_checks = 0;
	int cycles = 0;
	integer seed = 32'hd4f2af81;
	hmmbx_mailbox DUT (.*);
	hmmbx_host_model u_host (.*);
	initial core_clk = 1'b0;
	always #4 core_clk = ~core_clk;
	// ----
	// Checking
	// ----
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	function automatic logic [31:0] exp_status(logic [11:0] s);
		return {18'h0, s, 2'b01};
	endfunction
	function automatic logic [15:0] exp_total(logic [31:0] h);
		return h[31:16] + `HMMBX_HDR_BYTES;
	endfunction
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			tally_and_finish();
		end
	end
	// ----
	// Transmit
	// ----
	task automatic send(input logic [31:0] h, input logic [31:0] b);
		logic [31:0] r;
		u_host.wr(`HMMBX_ADDR_HEADER, h);
		repeat (2) @(posedge core_clk);
		#1;
		chk("group", 32'(h[7:0]), 32'(cpu_hdr_group));
		chk("opcode", 32'(h[15:8]), 32'(cpu_hdr_opcode));
		chk("total", 32'(exp_total(h)), 32'(cpu_hdr_total));
		u_host.wr(`HMMBX_ADDR_TX_DOORBELL, 32'h2);
		chk("tx_irq", 32'h1, 32'(cpu_tx_irq));
		u_host.rd(`HMMBX_ADDR_TX_DOORBELL, r);
		chk("bell_set", 32'h2, r & 32'h2);
		@(posedge core_clk);
		#1;
		cpu_alloc_valid = 1'b1;
		cpu_alloc_addr = b;
		@(posedge core_clk);
		#1;
		cpu_alloc_valid = 1'b0;
		u_host.rd(`HMMBX_ADDR_TX_DOORBELL, r);
		chk("bell_clear", 32'h0, r & 32'h2);
		u_host.rd(`HMMBX_ADDR_TX_BUFADDR, r);
		chk("buf_addr", b, r);
		if (b != 32'h0) begin
			u_host.wr(`HMMBX_ADDR_TX_DONE, (b << 2) | 32'h2);
			chk("done_irq", 32'h1, 32'(cpu_done_irq));
			chk("done_addr", b, cpu_done_addr);
		end
	endtask
	initial begin
		rst_b = 1'b0;
		cpu_alloc_valid = 1'b0;
		cpu_alloc_addr = 32'h0;
		cpu_msg_valid = 1'b0;
		cpu_msg_addr = 32'h0;
		cpu_msg_size = 12'h0;
		repeat (3) @(posedge core_clk);
		#1;
		rst_b = 1'b1;
		u_host.rd(`HMMBX_ADDR_HEADER, d);
		chk("asleep_read", 32'h0, d);
		u_host.wake();
		chk("awake", 32'h1, 32'(awake));
		// Last send gets a zero address, the allocation failure case
		for (int i = 0; i < 6; i++) begin
			a = ($random(seed) & 32'h0ffffffc) | 32'h4;
			send($random(seed), (i == 5) ? 32'h0 : a);
		end
		// ----
		// Receive: fill until refused, then drain in order
		// ----
		for (int i = 0; i < 22; i++) begin
			@(posedge core_clk);
			#1;
			cpu_msg_valid = cpu_msg_ready;
			cpu_msg_addr = $random(seed);
			cpu_msg_size = 12'($random(seed));
			if (cpu_msg_ready) q.push_back({cpu_msg_size, cpu_msg_addr});
		end
		@(posedge core_clk);
		#1;
		cpu_msg_valid = 1'b0;
		chk("refused", 32'h0, 32'(cpu_msg_ready));
		chk("accepted", 32'h1, 32'(q.size() >= 16));
		while (q.size() > 0) begin
			d = 32'h0;
			for (int t = 0; t < 8 && !d[0]; t++) u_host.rd(`HMMBX_ADDR_RX_STATUS, d);
			chk("rx_status", exp_status(q[0][43:32]), d & 32'h3ffd);
			u_host.rd(`HMMBX_ADDR_RX_ADDR, d);
			chk("rx_addr", q[0][31:0], d);
			u_host.wr(`HMMBX_ADDR_RX_STATUS, 32'h0);
			u_host.rd(`HMMBX_ADDR_RX_STATUS, d);
			chk("rx_clear", 32'h0, d & 32'h1);
			u_host.wr(`HMMBX_ADDR_RX_STATUS, 32'h2);
			chk("rx_free", 32'h1, 32'(cpu_rx_free));
			chk("rx_free_addr", q[0][31:0], cpu_rx_free_addr);
			void'(q.pop_front());
		end
		chk("drained", 32'h1, 32'(cpu_msg_ready));
		u_host.wr(`HMMBX_ADDR_WAKE, `HMMBX_SLEEP_VALUE);
		u_host.wr(`HMMBX_ADDR_CLKLESS, 32'h0);
		chk("asleep", 32'h0, 32'(awake));
		tally_and_finish();
	end
endmodule
